// file: design/mlic_defs.svh
// Purpose: Constants of the multilevel interrupt controller.
// Assumes: Included by its bare name in the controller design file only.
// Notes:   Register indexes are word indexes; byte address is index * 4.
`ifndef MLIC_DEFS_SVH
`define MLIC_DEFS_SVH

// Register indexes.
`define MLIC_IDX_STATUS  0
`define MLIC_IDX_LASTVEC 1
`define MLIC_IDX_CTRL    2

// Control field positions.
`define MLIC_CTRL_ROTATE 7
`define MLIC_CTRL_VECSEL 6
`define MLIC_CTRL_HIGHEN 2
`define MLIC_CTRL_MEDEN  1
`define MLIC_CTRL_LOWEN  0

// Status field positions.
`define MLIC_STAT_NMI  7
`define MLIC_STAT_HIGH 2
`define MLIC_STAT_MED  1
`define MLIC_STAT_LOW  0

// Reset value and write masks.
`define MLIC_REG_RESET   8'h00
`define MLIC_CTRL_WMASK  8'h87
`define MLIC_VECSEL_MASK 8'h40

// Address constants.
`define MLIC_RESET_APP     16'h0000
`define MLIC_APP_START     16'h0000
`define MLIC_VEC_TABLE_OFS 16'h0002

`endif

// file: design/mlic_multilevel_irq_ctrl.sv
// Purpose: Priority and level control of a three-level interrupt controller.
// Assumes: Requests and CPU strobes are synchronous to ref_clk.
// Notes:   Registers sit behind a classic Wishbone slave, 32-bit data.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "mlic_defs.svh"

// Summary of operation
// - Pick by level first, then priority.
// - Only low level may rotate; others static.
// - Static: lowest vector wins within level.
// - Rotation: last low vector goes last.
// - Acknowledged low vector loads last-vector register while rotation is on.
// - Software reads and writes last-vector register.
// - Disabling rotation keeps last-vector register.
// - Control bit 7 enables low rotation.
// - Control bit 6 selects boot vector table.
// - Reset address from fuse; table base +2.
// - Vector select writes need unlock.
// - Control bits 2..0 enable high/medium/low.
// - Disable takes effect one cycle later.
// - Status bit 7 marks non-maskable running.
// - Status bit 2 marks high running.
// - Status bits 1,0 mark medium, low running.
// - Level code: off, low, medium, high.
// - Higher level pre-empts lower running handler.
// - Nothing pre-empts a non-maskable handler.
// - Return restores previous executing state.
module mlic_multilevel_irq_ctrl
   import mlic_pkg::*;
#(
   parameter int          NUM_NMI         = 1,
   parameter int          NUM_SRC         = 8,
   parameter int          ADR_W           = 4,
   parameter logic [15:0] BOOT_RESET_ADDR = 16'h1000
)
(
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [ADR_W-1:0]          wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic [31:0]                    wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic [NUM_NMI-1:0]        nmiReq,
   input  wire mlic_level_e [NUM_SRC-1:0] srcLevel,
   input  wire logic                      cpuAck,
   input  wire logic                      cpuReturn,
   input  wire logic                      cfgUnlock,
   input  wire logic                      bootResetFuse,
   output mlic_pick_s                     irqPick_r,
   output logic [15:0]                    irqVecAddr_r,
   output logic [15:0]                    resetAddr_r
);

   localparam int IDX_W = ADR_W - 2; // Width of the word index.

   // Registers seen by software.
   logic [7:0]  status_r;    // Executing-level flags.
   logic [7:0]  lastVec_r;   // Last acknowledged low vector.
   logic [7:0]  ctrl_r;      // Level enables and scheme control.
   logic [7:0]  status_nxt;  // Next executing-level flags.
   logic [7:0]  lastVec_nxt; // Next last-vector value.
   logic [7:0]  ctrl_nxt;    // Next control value.

   // Bus decode.
   logic [IDX_W-1:0] regIdx;    // Word index of the access.
   logic             reqHit;    // New bus request this cycle.
   logic             wrByte;    // Write touching the low byte lane.
   logic             hitStatus; // Access to the status register.
   logic             hitLast;   // Access to the last-vector register.
   logic             hitCtrl;   // Access to the control register.
   logic             wrLast;    // Software write to last-vector.
   logic             wrCtrl;    // Software write to control.
   logic [7:0]       ctrlWMask; // Control bits that this write may change.
   logic [31:0]      rdData;    // Read data before the output register.

   // Arbitration.
   logic [NUM_SRC-1:0] highReq;   // Enabled high-level requests.
   logic [NUM_SRC-1:0] medReq;    // Enabled medium-level requests.
   logic [NUM_SRC-1:0] lowReq;    // Enabled low-level requests.
   logic               nmiAny;    // Any non-maskable request.
   logic               highAny;   // Any high request.
   logic               medAny;    // Any medium request.
   logic               lowAny;    // Any low request.
   logic [7:0]         nmiVec;    // Winning non-maskable vector.
   logic [7:0]         highVec;   // Winning high vector.
   logic [7:0]         medVec;    // Winning medium vector.
   logic [7:0]         lowVec;    // Winning low vector.
   logic               nmiOk;     // A non-maskable request may start.
   logic               highOk;    // A high request may start.
   logic               medOk;     // A medium request may start.
   logic               lowOk;     // A low request may start.
   mlic_pick_s         pickNxt;   // Winner of this cycle.
   mlic_pick_s         pickLoad;  // Value loaded into the presented pick.
   logic               ackTaken;  // CPU acknowledged a valid pick.
   logic [7:0]         ackSet;    // Status bit set by the acknowledge.
   logic [7:0]         retClr;    // Status bit cleared by the return.
   logic [15:0]        vecBase;   // Start of the vector table.
   logic [15:0]        reset_nxt; // Reset address from the fuse.

   // Status bit for a presented pick.
   function automatic logic [7:0] levelBit(input mlic_pick_s p);
      logic [7:0] b;
      b = 8'h00;
      if (p.nmi)
         b[`MLIC_STAT_NMI] = 1'b1;
      else if (p.level == LVL_HIGH)
         b[`MLIC_STAT_HIGH] = 1'b1;
      else if (p.level == LVL_MED)
         b[`MLIC_STAT_MED] = 1'b1;
      else if (p.level == LVL_LOW)
         b[`MLIC_STAT_LOW] = 1'b1;
      return b;
   endfunction : levelBit

   // Highest running flag, the one a return belongs to.
   function automatic logic [7:0] topBit(input logic [7:0] s);
      logic [7:0] b;
      b = 8'h00;
      if (s[`MLIC_STAT_NMI])
         b[`MLIC_STAT_NMI] = 1'b1;
      else if (s[`MLIC_STAT_HIGH])
         b[`MLIC_STAT_HIGH] = 1'b1;
      else if (s[`MLIC_STAT_MED])
         b[`MLIC_STAT_MED] = 1'b1;
      else if (s[`MLIC_STAT_LOW])
         b[`MLIC_STAT_LOW] = 1'b1;
      return b;
   endfunction : topBit

   // Bus decode: one request per ack, answered one cycle later.
   assign regIdx    = wb_adr_i[ADR_W-1:2];
   assign reqHit    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrByte    = reqHit && wb_we_i && wb_sel_i[0];
   assign hitStatus = regIdx == IDX_W'(`MLIC_IDX_STATUS);
   assign hitLast   = regIdx == IDX_W'(`MLIC_IDX_LASTVEC);
   assign hitCtrl   = regIdx == IDX_W'(`MLIC_IDX_CTRL);
   assign wrLast    = wrByte && hitLast;
   assign wrCtrl    = wrByte && hitCtrl;

   // Vector select only moves while the protection unlock is open.
   assign ctrlWMask = `MLIC_CTRL_WMASK | (cfgUnlock ? `MLIC_VECSEL_MASK : `MLIC_REG_RESET);
   // Reserved control bits never store, so they read back as zero.
   assign ctrl_nxt  = wrCtrl ? ((ctrl_r & ~ctrlWMask) | (wb_dat_i[7:0] & ctrlWMask)) : ctrl_r;

   // Unmapped words read as zero; status writes are ignored.
   assign rdData = hitStatus ? {24'h000000, status_r}
                 : hitLast   ? {24'h000000, lastVec_r}
                 : hitCtrl   ? {24'h000000, ctrl_r}
                 : 32'h00000000;

   // Sort requests by level code; a cleared enable hides its level.
   for (genvar g = 0; g < NUM_SRC; g++)
   begin : g_lvl
      assign highReq[g] = ctrl_r[`MLIC_CTRL_HIGHEN] && (srcLevel[g] == LVL_HIGH);
      assign medReq[g]  = ctrl_r[`MLIC_CTRL_MEDEN] && (srcLevel[g] == LVL_MED);
      assign lowReq[g]  = ctrl_r[`MLIC_CTRL_LOWEN] && (srcLevel[g] == LVL_LOW);
   end

   // Non-maskable class: always static order.
   mlic_pick_arb #(.N(NUM_NMI), .VEC_BASE(0)) u_arb_nmi
   (
      .req     (nmiReq),
      .rotate  (1'b0),
      .lastVec (lastVec_r),
      .anyReq  (nmiAny),
      .winVec  (nmiVec)
   );

   // High level: always static order.
   mlic_pick_arb #(.N(NUM_SRC), .VEC_BASE(NUM_NMI)) u_arb_high
   (
      .req     (highReq),
      .rotate  (1'b0),
      .lastVec (lastVec_r),
      .anyReq  (highAny),
      .winVec  (highVec)
   );

   // Medium level: always static order.
   mlic_pick_arb #(.N(NUM_SRC), .VEC_BASE(NUM_NMI)) u_arb_med
   (
      .req     (medReq),
      .rotate  (1'b0),
      .lastVec (lastVec_r),
      .anyReq  (medAny),
      .winVec  (medVec)
   );

   // Low level: rotation chosen by control bit 7.
   mlic_pick_arb #(.N(NUM_SRC), .VEC_BASE(NUM_NMI)) u_arb_low
   (
      .req     (lowReq),
      .rotate  (ctrl_r[`MLIC_CTRL_ROTATE]),
      .lastVec (lastVec_r),
      .anyReq  (lowAny),
      .winVec  (lowVec)
   );

   // A class may start only above every running level.
   assign nmiOk  = !status_r[`MLIC_STAT_NMI];
   assign highOk = nmiOk && !status_r[`MLIC_STAT_HIGH];
   assign medOk  = highOk && !status_r[`MLIC_STAT_MED];
   assign lowOk  = medOk && !status_r[`MLIC_STAT_LOW];

   // Level decides first, the class arbiter second.
   always_comb
   begin
      pickNxt = '0;
      if (nmiOk && nmiAny)
      begin
         pickNxt = '{valid: 1'b1, nmi: 1'b1, level: LVL_HIGH, vector: nmiVec};
      end
      else if (highOk && highAny)
      begin
         pickNxt = '{valid: 1'b1, nmi: 1'b0, level: LVL_HIGH, vector: highVec};
      end
      else if (medOk && medAny)
      begin
         pickNxt = '{valid: 1'b1, nmi: 1'b0, level: LVL_MED, vector: medVec};
      end
      else if (lowOk && lowAny)
      begin
         pickNxt = '{valid: 1'b1, nmi: 1'b0, level: LVL_LOW, vector: lowVec};
      end
   end

   // An acknowledge blanks the pick for a cycle, so the stale winner
   // cannot be taken twice before the new running state is seen.
   assign ackTaken = cpuAck && irqPick_r.valid;
   assign pickLoad = ackTaken ? '0 : pickNxt;

   // Return drops the top flag; an acknowledge in the same cycle still sets.
   assign ackSet    = ackTaken ? levelBit(irqPick_r) : `MLIC_REG_RESET;
   assign retClr    = cpuReturn ? topBit(status_r) : `MLIC_REG_RESET;
   assign status_nxt = (status_r & ~retClr) | ackSet;

   // A hardware load wins over a software write in the same cycle.
   // Nothing clears the register when rotation is switched off.
   assign lastVec_nxt = (ackTaken && !irqPick_r.nmi && (irqPick_r.level == LVL_LOW)
                         && ctrl_r[`MLIC_CTRL_ROTATE]) ? irqPick_r.vector
                      : wrLast ? wb_dat_i[7:0]
                      : lastVec_r;

   // Table base and reset address.
   assign vecBase  = ctrl_r[`MLIC_CTRL_VECSEL] ? (BOOT_RESET_ADDR + `MLIC_VEC_TABLE_OFS)
                                               : (`MLIC_APP_START + `MLIC_VEC_TABLE_OFS);
   assign reset_nxt = bootResetFuse ? `MLIC_RESET_APP : BOOT_RESET_ADDR;

   // Software-visible registers.
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         status_r  <= `MLIC_REG_RESET;
         lastVec_r <= `MLIC_REG_RESET;
         ctrl_r    <= `MLIC_REG_RESET;
      end
      else
      begin
         status_r  <= status_nxt;
         lastVec_r <= lastVec_nxt;
         ctrl_r    <= ctrl_nxt;
      end
   end

   // Bus answer.
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= reqHit;
         wb_dat_o <= reqHit ? rdData : wb_dat_o;
      end
   end

   // Presented request and addresses toward the CPU.
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         irqPick_r    <= '0;
         irqVecAddr_r <= 16'h0000;
         resetAddr_r  <= 16'h0000;
      end
      else
      begin
         irqPick_r    <= pickLoad;
         irqVecAddr_r <= vecBase + 16'({pickLoad.vector, 1'b0});
         resetAddr_r  <= reset_nxt;
      end
   end

   // Checks.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_ack_sets_high;
      cpuAck && irqPick_r.valid && !irqPick_r.nmi && irqPick_r.level == LVL_HIGH && !cpuReturn
         |=> status_r[`MLIC_STAT_HIGH];
   endproperty
   a_ack_sets_high: assert property (p_ack_sets_high) else $error("High flag not set by ack.");

   property p_nmi_sets;
      cpuAck && irqPick_r.valid && irqPick_r.nmi |=> status_r[`MLIC_STAT_NMI];
   endproperty
   a_nmi_sets: assert property (p_nmi_sets) else $error("Nmi flag not set by ack.");

   property p_nmi_blocks;
      status_r[`MLIC_STAT_NMI] |=> !irqPick_r.valid;
   endproperty
   a_nmi_blocks: assert property (p_nmi_blocks) else $error("Request shown during nmi handler.");

   property p_low_preempt;
      irqPick_r.valid && irqPick_r.level == LVL_LOW |-> !$past(status_r[`MLIC_STAT_LOW]);
   endproperty
   a_low_preempt: assert property (p_low_preempt) else $error("Low shown while low running.");

   property p_interrupt_return_restore;
      cpuReturn && !cpuAck && status_r[`MLIC_STAT_NMI]
         |=> !status_r[`MLIC_STAT_NMI] && status_r[2:0] == $past(status_r[2:0]);
   endproperty
   a_interrupt_return_restore: assert property (p_interrupt_return_restore) else $error("Return did not restore state.");

   property p_rr_load;
      ackTaken && !irqPick_r.nmi && irqPick_r.level == LVL_LOW && ctrl_r[`MLIC_CTRL_ROTATE]
         |=> lastVec_r == $past(irqPick_r.vector);
   endproperty
   a_rr_load: assert property (p_rr_load) else $error("Last vector not loaded.");

   property p_rr_off_hold;
      !ctrl_r[`MLIC_CTRL_ROTATE] && !wrLast |=> $stable(lastVec_r);
   endproperty
   a_rr_off_hold: assert property (p_rr_off_hold) else $error("Last vector changed.");

   property p_high_ignored;
      !ctrl_r[`MLIC_CTRL_HIGHEN] |=> !(irqPick_r.valid && !irqPick_r.nmi && irqPick_r.level == LVL_HIGH);
   endproperty
   a_high_ignored: assert property (p_high_ignored) else $error("Disabled high shown.");

   property p_vecsel_lock;
      wrCtrl && !cfgUnlock |=> $stable(ctrl_r[`MLIC_CTRL_VECSEL]);
   endproperty
   a_vecsel_lock: assert property (p_vecsel_lock) else $error("Vector select moved while locked.");

   property p_reset_addr;
      bootResetFuse ##1 bootResetFuse |-> resetAddr_r == `MLIC_RESET_APP;
   endproperty
   a_reset_addr: assert property (p_reset_addr) else $error("Wrong reset address.");

   c_nmi_run: cover property (ackTaken && irqPick_r.nmi);
   c_rr_load: cover property (ackTaken && irqPick_r.level == LVL_LOW && ctrl_r[`MLIC_CTRL_ROTATE]);
   c_nested:  cover property (status_r[`MLIC_STAT_LOW] && status_r[`MLIC_STAT_HIGH]);

endmodule : mlic_multilevel_irq_ctrl

// file: design/mlic_pick_arb.sv
// Purpose: Picks one vector among pending requests of one class.
// Assumes: Request bit i has vector VEC_BASE + i.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module mlic_pick_arb
   import mlic_pkg::*;
#(
   parameter int N        = 8,
   parameter int VEC_BASE = 1
)
(
   input  wire logic [N-1:0] req,
   input  wire logic         rotate,
   input  wire logic [7:0]   lastVec,
   output logic              anyReq,
   output logic [7:0]        winVec
);

   // Index of the lowest set bit, so the lowest vector wins.
   function automatic logic [7:0] lowestIdx(input logic [N-1:0] r);
      logic [7:0] idx;
      idx = 8'h00;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (r[i])
            idx = 8'(i);
      end
      return idx;
   endfunction : lowestIdx

   logic [N-1:0] servedMask; // Vectors at or below the last served one.
   logic [N-1:0] aheadReq;   // Requests that come after the last served.
   logic         useAhead;   // Some request lies past the pointer.
   logic [7:0]   winIdx;     // Winning request index.

   // Under rotation, vectors up to the last served one drop behind the rest.
   for (genvar g = 0; g < N; g++)
   begin : g_mask
      assign servedMask[g] = rotate && ((VEC_BASE + g) <= int'(lastVec));
   end

   assign aheadReq = req & ~servedMask;
   assign useAhead = |aheadReq;
   // Without rotation the mask is empty and the lowest vector wins.
   assign winIdx   = useAhead ? lowestIdx(aheadReq) : lowestIdx(req);
   assign anyReq   = |req;
   assign winVec   = winIdx + 8'(VEC_BASE);

endmodule : mlic_pick_arb

// file: design/mlic_pkg.sv
// Purpose: Types shared by the interrupt controller modules.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes:   Level codes are those carried by each request.
package mlic_pkg;

   // Two-bit request level code.
   typedef enum logic [1:0]
   {
      LVL_OFF  = 2'b00,
      LVL_LOW  = 2'b01,
      LVL_MED  = 2'b10,
      LVL_HIGH = 2'b11
   } mlic_level_e;

   // The request presented to the CPU.
   typedef struct packed
   {
      logic        valid;
      logic        nmi;
      mlic_level_e level;
      logic [7:0]  vector;
   } mlic_pick_s;

endpackage : mlic_pkg

// file: test/mlic_cpu_model.sv
// Purpose: Behavioural CPU core that takes presented picks and issues returns.
// Assumes: Requests from the bench are one-cycle pulses after a rising edge.
// Notes:   The acknowledge can be delayed to mimic a slow core.
`timescale 1ns/1ps
module mlic_cpu_model
   import mlic_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       takeReq,
   input  wire logic       retReq,
   input  wire logic [2:0] ackWait,
   input  wire mlic_pick_s irqPick_r,
   output logic            cpuAck,
   output logic            cpuReturn,
   output logic [7:0]      takenVec_r
);
   logic       pend_r;   // A take is waiting for a valid pick.
   logic [2:0] cnt_r;    // Remaining delay before acknowledge.

   // The core acknowledges only a valid pick and never twice in a row,
   // because the pick drops one cycle after it is taken.
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pend_r     <= 1'b0;
         cnt_r      <= 3'h0;
         cpuAck     <= 1'b0;
         cpuReturn  <= 1'b0;
         takenVec_r <= 8'h00;
      end
      else
      begin
         cpuAck    <= 1'b0;
         cpuReturn <= retReq;
         if (takeReq)
         begin
            pend_r <= 1'b1;
            cnt_r  <= ackWait;
         end
         else if (pend_r && irqPick_r.valid && !cpuAck)
         begin
            if (cnt_r != 3'h0)
               cnt_r <= cnt_r - 3'h1;
            else
            begin
               cpuAck     <= 1'b1;
               pend_r     <= 1'b0;
               takenVec_r <= irqPick_r.vector;
            end
         end
      end
   end
endmodule : mlic_cpu_model

// file: test/mlic_multilevel_irq_ctrl_tb_top.sv
// Purpose: Self-checking bench for the interrupt priority controller.
// Assumes: Default parameters, so source i carries vector i + 1.
// Notes:   Register bus is driven as a classic Wishbone master.
`timescale 1ns/1ps
module mlic_multilevel_irq_ctrl_tb_top
   import mlic_pkg::*;
;
   logic              ref_clk   = 1'b0;
   logic              reset_n   = 1'b0;
   logic              wbReq     = 1'b0;   // Drives both cyc and stb.
   logic              wbWe      = 1'b0;
   logic [3:0]        wbAdr     = 4'h0;
   logic [31:0]       wbDatI    = 32'h0;
   logic [31:0]       wbDatO;
   logic              wbAck;
   logic [0:0]        nmiReq    = 1'b0;
   mlic_level_e [7:0] srcLevel  = '{default: LVL_OFF};
   logic              cfgUnlock = 1'b0;
   logic              fuse      = 1'b1;
   logic              takeReq   = 1'b0;
   logic              retReq    = 1'b0;
   logic [2:0]        ackWait   = 3'h0;
   logic              cpuAck;
   logic              cpuReturn;
   mlic_pick_s        pick;
   logic [15:0]       vecAddr;
   logic [15:0]       rstAddr;
   logic [7:0]        takenVec;
   logic [7:0]        rdData;
   int                err_total  = 0;
   int                num_checks = 0;

   // Free-running 10 MHz clock.
   always #50 ref_clk = ~ref_clk;

   mlic_multilevel_irq_ctrl uut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wbReq),
      .wb_stb_i(wbReq), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .nmiReq(nmiReq), .srcLevel(srcLevel), .cpuAck(cpuAck),
      .cpuReturn(cpuReturn), .cfgUnlock(cfgUnlock), .bootResetFuse(fuse), .irqPick_r(pick),
      .irqVecAddr_r(vecAddr), .resetAddr_r(rstAddr));

   mlic_cpu_model cpu (.ref_clk(ref_clk), .reset_n(reset_n), .takeReq(takeReq), .retReq(retReq),
      .ackWait(ackWait), .irqPick_r(pick), .cpuAck(cpuAck), .cpuReturn(cpuReturn),
      .takenVec_r(takenVec));

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // Every comparison passes through here so counts stay consistent.
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One classic cycle; only the watchdog ends a wait on a silent slave.
   task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      wbReq  <= 1'b1;
      wbWe   <= w;
      wbAdr  <= a;
      wbDatI <= {24'h000000, d};
      @(posedge ref_clk);
      while (wbAck !== 1'b1)
         @(posedge ref_clk);
      rdData = wbDatO[7:0];
      wbReq <= 1'b0;
      wbWe  <= 1'b0;
      @(posedge ref_clk);
   endtask : wb

   task rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      wb(1'b0, a, 8'h00);
      chk(nm, {8'h00, e}, {8'h00, rdData});
   endtask : rd

   task take(input logic [2:0] w);
      takeReq <= 1'b1;
      ackWait <= w;
      @(posedge ref_clk);
      takeReq <= 1'b0;
      tick(7);
   endtask : take

   task ret();
      retReq <= 1'b1;
      @(posedge ref_clk);
      retReq <= 1'b0;
      tick(4);
   endtask : ret

   task lvl(input int i, input mlic_level_e l);
      srcLevel[i] <= l;
      tick(4);
   endtask : lvl

   task test_done();
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Main sequence; each step starts just after a rising edge.
   initial
   begin
      tick(6);
      reset_n <= 1'b1;
      tick(3);
      chk("resetAddr", 16'h0000, rstAddr);
      rd(4'h0, 8'h00, "status");
      rd(4'h4, 8'h00, "lastVec");
      rd(4'h8, 8'h00, "ctrl");
      wb(1'b1, 4'h0, 8'h87);
      rd(4'h0, 8'h00, "status read-only");
      wb(1'b1, 4'hc, 8'hff);
      rd(4'hc, 8'h00, "unmapped");
      $display("Test registers done");
      wb(1'b1, 4'h8, 8'hc7);
      rd(4'h8, 8'h87, "ctrl locked");
      cfgUnlock <= 1'b1;
      wb(1'b1, 4'h8, 8'h47);
      rd(4'h8, 8'h47, "ctrl unlocked");
      fuse <= 1'b0;
      tick(3);
      chk("resetAddr", 16'h1000, rstAddr);
      lvl(5, LVL_LOW);
      lvl(2, LVL_LOW);
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h03}), 16'(pick));
      chk("vecAddr boot", 16'h1008, vecAddr);
      wb(1'b1, 4'h8, 8'h07);
      tick(2);
      chk("vecAddr app", 16'h0008, vecAddr);
      cfgUnlock <= 1'b0;
      $display("Test static done");
      lvl(6, LVL_MED);
      lvl(7, LVL_HIGH);
      chk("pick", 16'({1'b1, 1'b0, LVL_HIGH, 8'h08}), 16'(pick));
      take(3'h2);
      chk("taken", 16'h0008, {8'h00, takenVec});
      rd(4'h0, 8'h04, "status high");
      chk("pick valid", 16'h0000, {15'h0000, pick.valid});
      lvl(7, LVL_OFF);
      nmiReq <= 1'b1;
      tick(4);
      chk("pick", 16'({1'b1, 1'b1, LVL_HIGH, 8'h00}), 16'(pick));
      take(3'h0);
      nmiReq <= 1'b0;
      rd(4'h0, 8'h84, "status nmi");
      lvl(4, LVL_HIGH);
      chk("pick valid", 16'h0000, {15'h0000, pick.valid});
      ret();
      rd(4'h0, 8'h04, "status back");
      ret();
      rd(4'h0, 8'h00, "status idle");
      chk("pick", 16'({1'b1, 1'b0, LVL_HIGH, 8'h05}), 16'(pick));
      lvl(4, LVL_OFF);
      chk("pick", 16'({1'b1, 1'b0, LVL_MED, 8'h07}), 16'(pick));
      take(3'h1);
      rd(4'h0, 8'h02, "status med");
      ret();
      lvl(6, LVL_OFF);
      $display("Test levels done");
      wb(1'b1, 4'h8, 8'h87);
      tick(2);
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h03}), 16'(pick));
      take(3'h0);
      rd(4'h4, 8'h03, "lastVec");
      rd(4'h0, 8'h01, "status low");
      ret();
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h06}), 16'(pick));
      take(3'h0);
      rd(4'h4, 8'h06, "lastVec");
      ret();
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h03}), 16'(pick));
      wb(1'b1, 4'h4, 8'h03);
      tick(2);
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h06}), 16'(pick));
      wb(1'b1, 4'h8, 8'h07);
      rd(4'h4, 8'h03, "lastVec kept");
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h03}), 16'(pick));
      wb(1'b1, 4'h4, 8'h00);
      $display("Test rotate done");
      wb(1'b1, 4'h8, 8'h06);
      tick(1);
      chk("pick valid", 16'h0000, {15'h0000, pick.valid});
      // A pending high request must vanish once its enable is cleared.
      lvl(7, LVL_HIGH);
      chk("pick", 16'({1'b1, 1'b0, LVL_HIGH, 8'h08}), 16'(pick));
      wb(1'b1, 4'h8, 8'h03);
      chk("pick", 16'({1'b1, 1'b0, LVL_LOW, 8'h03}), 16'(pick));
      lvl(7, LVL_OFF);
      wb(1'b1, 4'h8, 8'h00);
      fuse <= 1'b1;
      tick(3);
      chk("resetAddr", 16'h0000, rstAddr);
      $display("Test enable done");
      test_done();
   end

   // The tests need well under a millisecond; this cuts a hang short.
   initial
   begin
      #2000000;
      err_total++;
      test_done();
   end
endmodule : mlic_multilevel_irq_ctrl_tb_top
